// *** verilog/bdp_consts.svh ***
`ifndef BDP_CONSTS_SVH
`define BDP_CONSTS_SVH

// ----------------------------------------------------------------
// instruction fields
// ----------------------------------------------------------------
`define BDP_COND_MSB      31
`define BDP_COND_LSB      28
`define BDP_CLS_MSB       27
`define BDP_BR_CLS_LSB    25
`define BDP_DP_CLS_LSB    26
`define BDP_IMM_BIT       25
`define BDP_LINK_BIT      24
`define BDP_OP_MSB        24
`define BDP_OP_LSB        21
`define BDP_SET_BIT       20
`define BDP_RN_MSB        19
`define BDP_RN_LSB        16
`define BDP_RD_MSB        15
`define BDP_RD_LSB        12
`define BDP_ROT_MSB       11
`define BDP_ROT_LSB       8
`define BDP_IMM8_MSB      7
`define BDP_SHAMT_MSB     11
`define BDP_SHAMT_LSB     7
`define BDP_SHTYP_MSB     6
`define BDP_SHTYP_LSB     5
`define BDP_MUL_BIT       7
`define BDP_REGSH_BIT     4
`define BDP_RM_MSB        3
`define BDP_OFF_MSB       23

// ----------------------------------------------------------------
// class codes and special values
// ----------------------------------------------------------------
`define BDP_BR_CLASS      3'h5
`define BDP_DP_CLASS      2'h0
`define BDP_TEST_GRP      2'h2
`define BDP_PC_AHEAD      32'h0000_0008
`define BDP_NEXT_INSTR    32'h0000_0004
`define BDP_LINK_MASK     32'hFFFF_FFFC
`define BDP_LINK_IDX      4'hE
`define BDP_PC_IDX        4'hF
`define BDP_COND_NEVER    4'hF
`define BDP_FLAGS_RST     4'h0
`define BDP_REFILL_LAST   2'h1
`define BDP_FLAG_N        3
`define BDP_FLAG_Z        2
`define BDP_FLAG_C        1
`define BDP_FLAG_V        0

`endif

// *** verilog/bdp_pkg.sv ***
package bdp_pkg;

	typedef logic [31:0] bdp_word_t;
	typedef logic [3:0]  bdp_idx_t;

	typedef enum logic [1:0] {BDP_IDLE, BDP_EXEC, BDP_REFILL} bdp_state_e;

	typedef enum logic [3:0] {
		BDP_AND = 4'h0, BDP_EOR = 4'h1, BDP_SUB = 4'h2, BDP_RSB = 4'h3,
		BDP_ADD = 4'h4, BDP_ADC = 4'h5, BDP_SBC = 4'h6, BDP_RSC = 4'h7,
		BDP_AND_TEST = 4'h8, BDP_XOR_TEST = 4'h9, BDP_SUB_COMPARE = 4'hA,
		BDP_ADD_COMPARE = 4'hB, BDP_ORR = 4'hC, BDP_MOV = 4'hD,
		BDP_BIT_CLEAR = 4'hE, BDP_MVN = 4'hF
	} bdp_op_e;

	typedef enum logic [1:0] {BDP_LSL, BDP_LSR, BDP_ASR, BDP_ROR} bdp_shift_e;

endpackage

// *** verilog/bdp_rf_if.sv ***
`timescale 1ns/10ps
interface bdp_rf_if;
	bdp_pkg::bdp_idx_t  rd_a_idx;
	bdp_pkg::bdp_idx_t  rd_b_idx;
	bdp_pkg::bdp_word_t rd_a_data;
	bdp_pkg::bdp_word_t rd_b_data;
	logic               wr_en;
	bdp_pkg::bdp_idx_t  wr_idx;
	bdp_pkg::bdp_word_t wr_data;

	modport core (output rd_a_idx, rd_b_idx, wr_en, wr_idx, wr_data,
		input rd_a_data, rd_b_data);
	modport mem (input rd_a_idx, rd_b_idx, wr_en, wr_idx, wr_data,
		output rd_a_data, rd_b_data);
endinterface

// *** verilog/bdp_regfile.sv ***
`timescale 1ns/10ps
// ----------------------------------------------------------------
// general register bank, two registered reads, one write
// ----------------------------------------------------------------
module bdp_regfile
#(
	parameter int DEPTH = 16
)
(
	// clock
	input  wire logic i_clk,
	// register port
	bdp_rf_if.mem     rf
);
	bdp_pkg::bdp_word_t mem [DEPTH];
	bdp_pkg::bdp_word_t next_a;
	bdp_pkg::bdp_word_t next_b;

	// read data comes from the old contents on a same-cycle write
	always_comb
	begin
		next_a = mem[rf.rd_a_idx];
		next_b = mem[rf.rd_b_idx];
	end

	always_ff @(posedge i_clk)
	begin
		rf.rd_a_data <= next_a;
		rf.rd_b_data <= next_b;
		if (rf.wr_en)
		begin
			mem[rf.wr_idx] <= rf.wr_data;
		end
	end
endmodule

// *** verilog/bdp_core.sv ***
`timescale 1ns/10ps
`include "bdp_consts.svh"
// Operation
// - execute only when flags satisfy condition in bits 31:28, else no-op
// - branch carries a 24-bit signed word offset
// - target is offset shifted left two, sign-extended, added to pc
// - pc used for the target is branch address plus 8
// - link bit 24 set writes a return address to the link register
// - return address is the instruction right after the branch
// - link value has bits 1:0 cleared; status flags not saved
// - plain branch leaves the link register untouched
// - both branch forms take three cycles for pipeline refill
// - first operand always comes from register at bits 19:16
// - opcode picks the operation; result goes to register at bits 15:12
// - bit 25 picks shifted register or rotated 8-bit immediate
// - flag update bit decides whether flags are overwritten
// - four test operations only set flags, never write a result
// - fourteen flag tests; 1110 always, 1111 reserved
// - opcode selects one of sixteen operations, including bit clear
// - immediate is 8 bits zero-extended, rotated right by twice rot
// - arithmetic flags: signed overflow, carry out, zero, negative
module bdp_core
(
	// clock and reset
	input  wire logic               i_clk,
	input  wire logic               i_srst,
	// instruction issue
	input  wire logic               i_instr_valid,
	input  wire logic [31:0]        i_instr,
	input  wire logic [31:0]        i_instr_addr,
	output logic                    o_ready,
	// register preload, idle only
	input  wire logic               i_load_en,
	input  wire logic [3:0]         i_load_idx,
	input  wire logic [31:0]        i_load_data,
	// retire
	output logic                    o_done,
	output logic                    o_executed,
	output logic [3:0]              o_flags,
	// register writeback view
	output logic                    o_wb_valid,
	output logic [3:0]              o_wb_idx,
	output logic [31:0]             o_wb_data,
	// program counter redirect
	output logic                    o_pc_load,
	output logic [31:0]             o_pc_target
);
	bdp_rf_if rf ();

	bdp_regfile #(.DEPTH(16)) u_rf (.i_clk(i_clk), .rf(rf));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] ror32(input logic [31:0] v, input logic [4:0] n);
		ror32 = (v >> n) | (v << (6'd32 - {1'b0, n}));
	endfunction

	// condition table on N Z C V
	function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
		logic n;
		logic z;
		logic cy;
		logic v;
		logic r;
		n  = f[`BDP_FLAG_N];
		z  = f[`BDP_FLAG_Z];
		cy = f[`BDP_FLAG_C];
		v  = f[`BDP_FLAG_V];
		unique case (c[3:1])
			3'h0: r = z;
			3'h1: r = cy;
			3'h2: r = n;
			3'h3: r = v;
			3'h4: r = cy & ~z;
			3'h5: r = (n == v);
			3'h6: r = ~z & (n == v);
			3'h7: r = 1'b1;
		endcase
		// odd codes invert; 1110 always, reserved 1111 never runs
		if (c == `BDP_COND_NEVER)
			cond_pass = 1'b0;
		else if (c[3:1] == 3'h7)
			cond_pass = 1'b1;
		else
			cond_pass = r ^ c[0];
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	bdp_pkg::bdp_state_e state, next_state;
	logic [31:0] ir, next_ir;
	logic [31:0] ir_addr, next_ir_addr;
	logic [3:0]  flags, next_flags;
	logic [1:0]  refill, next_refill;
	logic        next_done;
	logic        next_executed;
	logic        next_wb_valid;
	logic [3:0]  next_wb_idx;
	logic [31:0] next_wb_data;
	logic        next_pc_load;
	logic [31:0] next_pc_target;

	// ----------------------------------------------------------------
	// decode and datapath of the held instruction
	// ----------------------------------------------------------------
	logic        is_br, is_dp, run, writes_rd, arith;
	logic [31:0] pc8, opa, rm_val, op2, res, ax, ay, offset;
	logic [32:0] sum;
	logic        acin;
	logic [4:0]  shamt;
	bdp_pkg::bdp_op_e op;

	always_comb
	begin
		op     = bdp_pkg::bdp_op_e'(ir[`BDP_OP_MSB:`BDP_OP_LSB]);
		pc8    = ir_addr + `BDP_PC_AHEAD;
		is_br  = ir[`BDP_CLS_MSB:`BDP_BR_CLS_LSB] == `BDP_BR_CLASS;
		// multiply/swap and flagless test forms belong to other classes
		is_dp  = ir[`BDP_CLS_MSB:`BDP_DP_CLS_LSB] == `BDP_DP_CLASS
			&& !(!ir[`BDP_IMM_BIT] && ir[`BDP_MUL_BIT] && ir[`BDP_REGSH_BIT])
			&& !(op[3:2] == `BDP_TEST_GRP && !ir[`BDP_SET_BIT]);
		run    = cond_pass(ir[`BDP_COND_MSB:`BDP_COND_LSB], flags);
		// reading the pc register yields the prefetched address
		opa    = (ir[`BDP_RN_MSB:`BDP_RN_LSB] == `BDP_PC_IDX) ? pc8 : rf.rd_a_data;
		rm_val = (ir[`BDP_RM_MSB:0] == `BDP_PC_IDX) ? pc8 : rf.rd_b_data;
		shamt  = ir[`BDP_SHAMT_MSB:`BDP_SHAMT_LSB];
		if (ir[`BDP_IMM_BIT])
			op2 = ror32({24'h00_0000, ir[`BDP_IMM8_MSB:0]},
				{ir[`BDP_ROT_MSB:`BDP_ROT_LSB], 1'b0});
		else if (ir[`BDP_REGSH_BIT])
			op2 = rm_val; // register-held amount not modelled: passes unshifted
		else
		begin
			unique case (bdp_pkg::bdp_shift_e'(ir[`BDP_SHTYP_MSB:`BDP_SHTYP_LSB]))
				bdp_pkg::BDP_LSL: op2 = rm_val << shamt;
				bdp_pkg::BDP_LSR: op2 = (shamt == 5'h00) ? 32'h0000_0000 : rm_val >> shamt;
				bdp_pkg::BDP_ASR: op2 = (shamt == 5'h00) ? {32{rm_val[31]}}
					: 32'($signed(rm_val) >>> shamt);
				bdp_pkg::BDP_ROR: op2 = (shamt == 5'h00)
					? {flags[`BDP_FLAG_C], rm_val[31:1]} : ror32(rm_val, shamt);
			endcase
		end
		// adder operands; subtraction as add of inverse plus carry-in
		arith = 1'b1;
		ax    = opa;
		ay    = op2;
		acin  = 1'b0;
		unique case (op)
			bdp_pkg::BDP_SUB, bdp_pkg::BDP_SUB_COMPARE: begin ay = ~op2; acin = 1'b1; end
			bdp_pkg::BDP_RSB: begin ax = op2; ay = ~opa; acin = 1'b1; end
			bdp_pkg::BDP_ADD, bdp_pkg::BDP_ADD_COMPARE: acin = 1'b0;
			bdp_pkg::BDP_ADC: acin = flags[`BDP_FLAG_C];
			bdp_pkg::BDP_SBC: begin ay = ~op2; acin = flags[`BDP_FLAG_C]; end
			bdp_pkg::BDP_RSC: begin ax = op2; ay = ~opa; acin = flags[`BDP_FLAG_C]; end
			default: arith = 1'b0;
		endcase
		sum = {1'b0, ax} + {1'b0, ay} + {32'h0000_0000, acin};
		unique case (op)
			bdp_pkg::BDP_AND, bdp_pkg::BDP_AND_TEST: res = opa & op2;
			bdp_pkg::BDP_EOR, bdp_pkg::BDP_XOR_TEST: res = opa ^ op2;
			bdp_pkg::BDP_ORR:       res = opa | op2;
			bdp_pkg::BDP_MOV:       res = op2;
			bdp_pkg::BDP_BIT_CLEAR: res = opa & ~op2;
			bdp_pkg::BDP_MVN:       res = ~op2;
			default:                res = sum[31:0];
		endcase
		writes_rd = op[3:2] != `BDP_TEST_GRP;
		offset    = {{6{ir[`BDP_OFF_MSB]}}, ir[`BDP_OFF_MSB:0], 2'b00};
	end

	// ----------------------------------------------------------------
	// sequencer and register file drive
	// ----------------------------------------------------------------
	always_comb
	begin
		next_state     = state;
		next_ir        = ir;
		next_ir_addr   = ir_addr;
		next_flags     = flags;
		next_refill    = refill;
		next_done      = 1'b0;
		next_executed  = o_executed;
		next_wb_valid  = 1'b0;
		next_wb_idx    = o_wb_idx;
		next_wb_data   = o_wb_data;
		next_pc_load   = 1'b0;
		next_pc_target = o_pc_target;
		o_ready        = state == bdp_pkg::BDP_IDLE;
		rf.rd_a_idx    = i_instr[`BDP_RN_MSB:`BDP_RN_LSB];
		rf.rd_b_idx    = i_instr[`BDP_RM_MSB:0];
		rf.wr_en       = 1'b0;
		rf.wr_idx      = i_load_idx;
		rf.wr_data     = i_load_data;
		unique case (state)
			bdp_pkg::BDP_IDLE:
			begin
				rf.wr_en = i_load_en;
				if (i_instr_valid)
				begin
					next_ir      = i_instr;
					next_ir_addr = i_instr_addr;
					next_state   = bdp_pkg::BDP_EXEC;
				end
			end
			bdp_pkg::BDP_EXEC:
			begin
				next_executed = run && (is_br || is_dp);
				next_state    = bdp_pkg::BDP_IDLE;
				next_done     = 1'b1;
				if (is_br)
				begin
					// refill keeps the branch busy for two more cycles
					next_state  = bdp_pkg::BDP_REFILL;
					next_refill = `BDP_REFILL_LAST;
					next_done   = 1'b0;
					if (run)
					begin
						next_pc_load   = 1'b1;
						next_pc_target = pc8 + offset;
						// link only when bit 24 set, flags never saved
						if (ir[`BDP_LINK_BIT])
						begin
							rf.wr_en   = 1'b1;
							rf.wr_idx  = `BDP_LINK_IDX;
							rf.wr_data = (ir_addr + `BDP_NEXT_INSTR) & `BDP_LINK_MASK;
						end
					end
				end
				else if (is_dp && run)
				begin
					if (writes_rd)
					begin
						rf.wr_en   = 1'b1;
						rf.wr_idx  = ir[`BDP_RD_MSB:`BDP_RD_LSB];
						rf.wr_data = res;
					end
					if (ir[`BDP_SET_BIT])
					begin
						next_flags[`BDP_FLAG_N] = res[31];
						next_flags[`BDP_FLAG_Z] = res == 32'h0000_0000;
						if (arith)
						begin
							next_flags[`BDP_FLAG_C] = sum[32];
							next_flags[`BDP_FLAG_V] = (ax[31] == ay[31])
								&& (sum[31] != ax[31]);
						end
					end
				end
				next_wb_valid = rf.wr_en;
				next_wb_idx   = rf.wr_idx;
				next_wb_data  = rf.wr_data;
			end
			bdp_pkg::BDP_REFILL:
			begin
				next_refill = refill - 2'h1;
				if (refill == 2'h0)
				begin
					next_state = bdp_pkg::BDP_IDLE;
					next_done  = 1'b1;
				end
			end
			default: next_state = bdp_pkg::BDP_IDLE;
		endcase
	end

	// only registers here
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			state       <= bdp_pkg::BDP_IDLE;
			ir          <= 32'h0000_0000;
			ir_addr     <= 32'h0000_0000;
			flags       <= `BDP_FLAGS_RST;
			refill      <= 2'h0;
			o_done      <= 1'b0;
			o_executed  <= 1'b0;
			o_wb_valid  <= 1'b0;
			o_wb_idx    <= 4'h0;
			o_wb_data   <= 32'h0000_0000;
			o_pc_load   <= 1'b0;
			o_pc_target <= 32'h0000_0000;
		end
		else
		begin
			state       <= next_state;
			ir          <= next_ir;
			ir_addr     <= next_ir_addr;
			flags       <= next_flags;
			refill      <= next_refill;
			o_done      <= next_done;
			o_executed  <= next_executed;
			o_wb_valid  <= next_wb_valid;
			o_wb_idx    <= next_wb_idx;
			o_wb_data   <= next_wb_data;
			o_pc_load   <= next_pc_load;
			o_pc_target <= next_pc_target;
		end
	end

	assign o_flags = flags;
endmodule

// *** sim/bdp_core_assertions.sv ***
`timescale 1ns/10ps
// ------------------------------------------------
// port level checks of the core
// ------------------------------------------------
module bdp_core_assertions
(
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_srst,
	// issue and preload
	input  wire logic        i_instr_valid,
	input  wire logic [31:0] i_instr,
	input  wire logic [31:0] i_instr_addr,
	input  wire logic        o_ready,
	input  wire logic        i_load_en,
	input  wire logic [3:0]  i_load_idx,
	input  wire logic [31:0] i_load_data,
	// retire, writeback, redirect
	input  wire logic        o_done,
	input  wire logic        o_executed,
	input  wire logic [3:0]  o_flags,
	input  wire logic        o_wb_valid,
	input  wire logic [3:0]  o_wb_idx,
	input  wire logic [31:0] o_wb_data,
	input  wire logic        o_pc_load,
	input  wire logic [31:0] o_pc_target
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	// issue decode seen from outside
	wire         iss = i_instr_valid && o_ready;
	wire         br  = i_instr[27:25] == 3'h5;
	wire         al  = i_instr[31:28] == 4'hE;
	logic [31:0] cap_addr;
	logic [23:0] cap_off;
	// held while busy, no second issue can disturb it
	always_ff @(posedge i_clk)
		if (iss)
		begin
			cap_addr <= i_instr_addr;
			cap_off  <= i_instr[23:0];
		end
	a_dp_two_cycles: assert property (iss && !br |=> !o_ready ##1 (o_done && o_ready))
		else $error("non-branch retire timing wrong");
	a_br_four_cycles: assert property (iss && br |=> !o_ready [*3] ##1 o_done)
		else $error("branch retire timing wrong");
	a_br_target: assert property (iss && br && al |-> ##2 o_pc_load &&
		o_pc_target == cap_addr + 32'h0000_0008 + {{6{cap_off[23]}}, cap_off, 2'h0})
		else $error("branch target wrong");
	a_link_write: assert property (iss && br && al && i_instr[24] |-> ##2 o_wb_valid &&
		o_wb_idx == 4'hE && o_wb_data == ((cap_addr + 32'h0000_0004) & 32'hFFFF_FFFC))
		else $error("link value wrong");
	a_plain_no_link: assert property (iss && br && !i_instr[24] |=> !o_wb_valid [*4])
		else $error("plain branch wrote a register");
	a_never_quiet: assert property (iss && i_instr[31:28] == 4'hF |=> (!o_wb_valid && !o_pc_load) [*2])
		else $error("reserved condition had an effect");
	a_test_no_write: assert property (iss && i_instr[27:26] == 2'h0 &&
		i_instr[24:23] == 2'h2 |=> ##1 !o_wb_valid)
		else $error("test operation wrote a register");
	a_no_s_flags: assert property (iss && i_instr[27:26] == 2'h0 && !i_instr[20]
		|=> ##1 $stable(o_flags))
		else $error("flags changed without update bit");
	cover property (iss && br && i_instr[24]);
	cover property (iss && !br && i_instr[25]);
	cover property (o_done && !o_executed);
endmodule

bind bdp_core bdp_core_assertions chk
(
	.i_clk(i_clk), .i_srst(i_srst), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
	.i_instr_addr(i_instr_addr), .o_ready(o_ready), .i_load_en(i_load_en),
	.i_load_idx(i_load_idx), .i_load_data(i_load_data), .o_done(o_done),
	.o_executed(o_executed), .o_flags(o_flags), .o_wb_valid(o_wb_valid),
	.o_wb_idx(o_wb_idx), .o_wb_data(o_wb_data), .o_pc_load(o_pc_load),
	.o_pc_target(o_pc_target)
);

// *** sim/bdp_core_test.sv ***
`timescale 1ns/10ps
module bdp_core_test;
	// ------------------------------------------------
	// stimulus and observed outputs
	// ------------------------------------------------
	logic        i_clk         = 1'b0;
	logic        i_srst        = 1'b1;
	logic        i_instr_valid = 1'b0;
	logic [31:0] i_instr       = 32'h0000_0000;
	logic [31:0] i_instr_addr  = 32'h0000_0000;
	logic        i_load_en     = 1'b0;
	logic [3:0]  i_load_idx    = 4'h0;
	logic [31:0] i_load_data   = 32'h0000_0000;
	logic        o_ready, o_done, o_executed, o_wb_valid, o_pc_load, saw_wb, saw_pc;
	logic [3:0]  o_flags, o_wb_idx;
	logic [31:0] o_wb_data, o_pc_target;
	int          fails       = 0;
	int          comparisons = 0;
	int          cyc;
	// 40 MHz
	always #12.5 i_clk = ~i_clk;
	bdp_core uut
	(
		.i_clk(i_clk), .i_srst(i_srst), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
		.i_instr_addr(i_instr_addr), .o_ready(o_ready), .i_load_en(i_load_en),
		.i_load_idx(i_load_idx), .i_load_data(i_load_data), .o_done(o_done),
		.o_executed(o_executed), .o_flags(o_flags), .o_wb_valid(o_wb_valid),
		.o_wb_idx(o_wb_idx), .o_wb_data(o_wb_data), .o_pc_load(o_pc_load),
		.o_pc_target(o_pc_target)
	);
	// ------------------------------------------------
	// shared tasks
	// ------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic load(input logic [3:0] idx, input logic [31:0] val);
		@(posedge i_clk);
		i_load_en   <= 1'b1;
		i_load_idx  <= idx;
		i_load_data <= val;
		@(posedge i_clk);
		i_load_en <= 1'b0;
	endtask
	// issue one word, then collect pulses until retire; bounded so a hang shows
	task automatic run(input logic [31:0] ins, input logic [31:0] adr);
		@(posedge i_clk);
		i_instr       <= ins;
		i_instr_addr  <= adr;
		i_instr_valid <= 1'b1;
		@(posedge i_clk);
		i_instr_valid <= 1'b0;
		saw_wb = 1'b0;
		saw_pc = 1'b0;
		cyc    = 0;
		do
		begin
			@(posedge i_clk);
			#1;
			cyc++;
			saw_wb |= o_wb_valid;
			saw_pc |= o_pc_load;
		end
		while (o_done !== 1'b1 && cyc < 8);
		// a run that hit the cycle limit never retired
		check(o_done, 1'b1);
	endtask
	// ------------------------------------------------
	// scenarios
	// ------------------------------------------------
	// all sixteen opcodes, first operand 8000_0001, second 8000_0000
	task automatic t_dp_ops;
		logic [31:0] res [16] = '{32'h8000_0000, 32'h1, 32'h1, 32'hFFFF_FFFF, 32'h1, 32'h1,
			32'h0, 32'hFFFF_FFFE, 32'h0, 32'h0, 32'h0, 32'h0, 32'h8000_0001, 32'h8000_0000,
			32'h1, 32'h7FFF_FFFF};
		logic [3:0]  flg [16] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h8, 4'h0,
			4'h2, 4'h3, 4'h3, 4'h3, 4'h3, 4'h3};
		for (int op = 0; op < 16; op++)
		begin
			run({4'hE, 3'h0, op[3:0], op[3:2] == 2'h2, 4'h1, 4'h3, 12'h002}, 32'h0);
			check(o_flags, flg[op]);
			if (op[3:2] == 2'h2)
				check(saw_wb, 1'b0);
			else
			begin
				check(o_wb_idx, 4'h3);
				check(o_wb_data, res[op]);
			end
		end
		// compare without the update bit is not a valid test
		run({4'hE, 3'h0, 4'hA, 1'b0, 4'h1, 4'h3, 12'h002}, 32'h0);
		check({saw_wb, o_executed}, 2'h0);
		// bits 7 and 4 both set belong to the multiply class, not data processing
		run({4'hE, 3'h0, 4'h4, 1'b0, 4'h1, 4'h3, 12'h092}, 32'h0);
		check({saw_wb, o_executed}, 2'h0);
	endtask
	task automatic t_imm;
		// immediate shift forms; rrx picks up the carry left set by t_dp_ops
		logic [6:0]  shf [4] = '{7'h05, 7'h06, 7'h13, 7'h03};
		logic [31:0] shv [4] = '{32'h4000_0000, 32'hC000_0000, 32'h1800_0000, 32'hC000_0000};
		run({4'hE, 3'h1, 4'hD, 1'b0, 4'h0, 4'h4, 4'h4, 8'hFF}, 32'h0);
		check(o_wb_data, 32'hFF00_0000);
		check(cyc, 1);
		run({4'hE, 3'h1, 4'h4, 1'b0, 4'h1, 4'h5, 4'h0, 8'h01}, 32'h0);
		check(o_wb_data, 32'h8000_0002);
		for (int i = 0; i < 4; i++)
		begin
			run({4'hE, 3'h0, 4'hD, 1'b0, 4'h0, 4'h7, shf[i], 1'b0, 4'h1}, 32'h0);
			check(o_wb_data, shv[i]);
		end
	endtask
	// flags Z and C set, then every condition code
	task automatic t_cond;
		logic [15:0] pass = 16'h66A5;
		run({4'hE, 3'h0, 4'hA, 1'b1, 4'h1, 4'h0, 12'h001}, 32'h0);
		check(o_flags, 4'h6);
		for (int c = 0; c < 16; c++)
		begin
			run({c[3:0], 3'h1, 4'hD, 1'b0, 4'h0, 4'h6, 12'h007}, 32'h0);
			check(o_executed, pass[c]);
			check(saw_wb, pass[c]);
		end
	endtask
	task automatic t_branch;
		run({4'hE, 3'h5, 1'b0, 24'hFFFFFE}, 32'h0000_0100);
		check({saw_pc, saw_wb}, 2'h2);
		check(o_pc_target, 32'h0000_0100);
		check(cyc, 3);
		run({4'hE, 3'h5, 1'b1, 24'h000010}, 32'h0000_0203);
		check(o_pc_target, 32'h0000_024B);
		check(o_wb_idx, 4'hE);
		check(o_wb_data, 32'h0000_0204);
		check(o_flags, 4'h6);
		check(cyc, 3);
		run({4'h1, 3'h5, 1'b1, 24'h000010}, 32'h0000_0300);
		check({saw_pc, saw_wb}, 2'h0);
	endtask
	// reset between runs, with the core idle, clears flags and outputs, then work resumes
	task automatic t_reset;
		@(posedge i_clk);
		i_srst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_srst <= 1'b0;
		#1;
		check({o_ready, o_flags, o_wb_valid, o_done}, 7'h40);
		check(o_pc_target, 32'h0000_0000);
		run({4'hE, 3'h1, 4'hD, 1'b0, 4'h0, 4'h8, 12'h05A}, 32'h0);
		check(o_wb_data, 32'h0000_005A);
		check(o_flags, 4'h0);
	endtask
	task automatic final_report;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (4) @(posedge i_clk);
		i_srst <= 1'b0;
		load(4'h1, 32'h8000_0001);
		load(4'h2, 32'h8000_0000);
		t_dp_ops();
		t_imm();
		t_cond();
		t_branch();
		t_reset();
		final_report();
	end
	// watchdog, over twenty-five times the expected run
	initial
	begin
		#(25 * 4000);
		fails++;
		final_report();
	end
endmodule
